// [design/lane_status_regs.sv]
`timescale 1ns/100ps
`default_nettype none
module lane_status_regs (
  input  wire logic                                     CLK_SYS,
  input  wire logic                                     RST_N,
  input  wire logic                                     PSEL,
  input  wire logic                                     PENABLE,
  input  wire logic                                     PWRITE,
  input  wire logic [lane_status_pkg::ADDR_W-1:0]       PADDR,
  input  wire logic [lane_status_pkg::DATA_W-1:0]       PWDATA,
  output logic      [lane_status_pkg::DATA_W-1:0]       PRDATA,
  output logic                                          PREADY,
  output logic                                          PSLVERR,
  input  wire logic [lane_status_pkg::LINK_LANES-1:0]   UNEXP_CTRL_ERR,
  input  wire logic [lane_status_pkg::LINK_LANES-1:0]   GROUP_LOCK_RAW,
  output logic                                          IRQ
);
  import lane_status_pkg::*;

  // Word-aligned index match, used for every register
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [IDX_W-1:0]  idx);
    reg_hit = (addr[1:0] == 2'b00) && (addr[ADDR_W-1:2] == idx);
  endfunction

  // Bus request carried as one struct
  apb_req_t req;

  assign req.sel    = PSEL;
  assign req.enable = PENABLE;
  assign req.write  = PWRITE;
  assign req.addr   = PADDR;
  assign req.wdata  = PWDATA;

  // Bus-facing registers
  logic [DATA_W-1:0] prdata_q;
  logic [DATA_W-1:0] prdata_d;
  logic              pready_q;
  logic              pslverr_q;
  logic              pslverr_d;
  logic              irq_q;
  logic              irq_d;

  // Software controls and interrupt status
  logic              link_page_q;
  logic              link_page_d;
  logic [7:0]        threshold_q;
  logic [7:0]        threshold_d;
  logic [IRQ_W-1:0]  irq_enable_q;
  logic [IRQ_W-1:0]  irq_enable_d;
  logic [IRQ_W-1:0]  irq_status_q;
  logic [IRQ_W-1:0]  irq_status_d;

  // Lane state
  logic [LINK_LANES-1:0] lock_sync;
  logic [LINK_LANES-1:0] lock_q;
  logic [LINK_LANES-1:0] uek_flag;
  logic [LINK_LANES-1:0] uek_prev_q;
  logic [LINK_LANES-1:0] cnt_clear;

  // Access phase decode
  logic access;
  logic rd_take;
  logic wr_fire;

  // Read data is latched in the first access cycle, PREADY follows one later
  assign access  = req.sel && req.enable;
  assign rd_take = access && !pready_q && !req.write;
  assign wr_fire = access && pready_q && req.write;

  // Address decode
  logic hit_page;
  logic hit_uek;
  logic hit_lock;
  logic hit_thresh;
  logic hit_status;
  logic hit_enable;
  logic hit_clear;
  logic hit_cnt_clr;
  logic mapped;

  assign hit_page    = reg_hit(req.addr, IDX_LINK_PAGE);
  assign hit_uek     = reg_hit(req.addr, IDX_UNEXP_CTRL);
  assign hit_lock    = reg_hit(req.addr, IDX_GROUP_LOCK);
  assign hit_thresh  = reg_hit(req.addr, IDX_ERR_THRESH);
  assign hit_status  = reg_hit(req.addr, IDX_IRQ_STATUS);
  assign hit_enable  = reg_hit(req.addr, IDX_IRQ_ENABLE);
  assign hit_clear   = reg_hit(req.addr, IDX_IRQ_CLEAR);
  assign hit_cnt_clr = reg_hit(req.addr, IDX_CNT_CLEAR);
  assign mapped      = hit_page | hit_uek | hit_lock | hit_thresh |
                       hit_status | hit_enable | hit_clear | hit_cnt_clr;

  // Lock inputs come from the lane receivers' own clocks
  lane_lock_sync u_lock_sync (
    .clk      (CLK_SYS),
    .rst_n    (RST_N),
    .raw_in   (GROUP_LOCK_RAW),
    .sync_out (lock_sync)
  );

  // Per lane of each link: error counter and status packing
  link_status_t link_status [NUM_LINKS];

  genvar gl;
  genvar gn;
  generate
    for (gl = 0; gl < NUM_LINKS; gl++) begin : g_link
      for (gn = 0; gn < NUM_LANES; gn++) begin : g_lane
        // Counter clear acts only on lanes of the paged link
        assign cnt_clear[gl*NUM_LANES+gn] = wr_fire && hit_cnt_clr &&
                                            (link_page_q == gl) && req.wdata[gn];

        // One flag per lane, bit position equals lane number
        lane_error_counter u_counter (
          .clk       (CLK_SYS),
          .rst_n     (RST_N),
          .err_pulse (UNEXP_CTRL_ERR[gl*NUM_LANES+gn]),
          .clear     (cnt_clear[gl*NUM_LANES+gn]),
          .threshold (threshold_q),
          .flag_q    (uek_flag[gl*NUM_LANES+gn])
        );

        assign link_status[gl].unexp_flags[gn] = uek_flag[gl*NUM_LANES+gn];
        assign link_status[gl].group_lock[gn]  = lock_q[gl*NUM_LANES+gn];
      end
    end
  endgenerate

  // Paged view of the two status registers
  link_status_t page_status;

  assign page_status = link_status[link_page_q];

  // Interrupt events: threshold reached, or lock lost, on any link
  logic [NUM_LANES-1:0] uek_rise;
  logic [NUM_LANES-1:0] lock_loss;
  logic [IRQ_W-1:0]     irq_events;

  generate
    for (gn = 0; gn < NUM_LANES; gn++) begin : g_event
      logic [NUM_LINKS-1:0] rise_per_link;
      logic [NUM_LINKS-1:0] loss_per_link;
      for (gl = 0; gl < NUM_LINKS; gl++) begin : g_ev_link
        assign rise_per_link[gl] = uek_flag[gl*NUM_LANES+gn] & ~uek_prev_q[gl*NUM_LANES+gn];
        assign loss_per_link[gl] = lock_q[gl*NUM_LANES+gn] & ~lock_sync[gl*NUM_LANES+gn];
      end
      assign uek_rise[gn]  = |rise_per_link;
      assign lock_loss[gn] = |loss_per_link;
    end
  endgenerate

  // Low byte: flag rises; high byte: lock losses
  assign irq_events = {lock_loss, uek_rise};

  // Software writes; status registers have no write path at all
  logic [IRQ_W-1:0] irq_clear_mask;

  // Write strobes reach the read-write words and the two write-only clear words only
  assign link_page_d    = (wr_fire && hit_page) ? req.wdata[PAGE_POS] : link_page_q;
  assign threshold_d    = (wr_fire && hit_thresh) ? req.wdata[7:0] : threshold_q;
  assign irq_enable_d   = (wr_fire && hit_enable) ? req.wdata[IRQ_W-1:0] : irq_enable_q;
  assign irq_clear_mask = (wr_fire && hit_clear) ? req.wdata[IRQ_W-1:0] : IRQ_RESET;

  // New event wins over a clear in the same cycle
  assign irq_status_d = (irq_status_q & ~irq_clear_mask) | irq_events;
  assign irq_d        = |(irq_status_q & irq_enable_q);

  // Read mux; lane status zero-extends to the word
  logic [DATA_W-1:0] rd_page;
  logic [DATA_W-1:0] rd_uek;
  logic [DATA_W-1:0] rd_lock;
  logic [DATA_W-1:0] rd_thresh;
  logic [DATA_W-1:0] rd_status;
  logic [DATA_W-1:0] rd_enable;

  // Each readable word, zero-extended to the bus
  assign rd_page   = {{(DATA_W-1){1'b0}}, link_page_q};
  assign rd_uek    = {{(DATA_W-NUM_LANES){1'b0}}, page_status.unexp_flags};
  assign rd_lock   = {{(DATA_W-NUM_LANES){1'b0}}, page_status.group_lock};
  assign rd_thresh = {{(DATA_W-8){1'b0}}, threshold_q};
  assign rd_status = {{(DATA_W-IRQ_W){1'b0}}, irq_status_q};
  assign rd_enable = {{(DATA_W-IRQ_W){1'b0}}, irq_enable_q};

  // Write-only clear registers and unmapped words read as zero
  assign prdata_d = !rd_take   ? prdata_q  :
                    hit_page   ? rd_page   :
                    hit_uek    ? rd_uek    :
                    hit_lock   ? rd_lock   :
                    hit_thresh ? rd_thresh :
                    hit_status ? rd_status :
                    hit_enable ? rd_enable :
                    RDATA_RESET;

  // Error only for unmapped words; writes to status words are quietly dropped
  assign pslverr_d = access && !pready_q && !mapped;

  // APB handshake: one wait state, fixed
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= access && !pready_q;
    end
  end

  // Error rides with PREADY and never outlives it
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= pslverr_d;
    end
  end

  // Read data holds until the next read replaces it
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      prdata_q <= RDATA_RESET;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // Link page; a switch applies to the very next read
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      link_page_q <= 1'b0;
    end else begin
      link_page_q <= link_page_d;
    end
  end

  // Threshold shared by every lane counter
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      threshold_q <= THRESH_RESET;
    end else begin
      threshold_q <= threshold_d;
    end
  end

  // Interrupt enables, same layout as the status
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      irq_enable_q <= IRQ_RESET;
    end else begin
      irq_enable_q <= irq_enable_d;
    end
  end

  // Lane lock status: reset to zero, refreshed every cycle
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      lock_q <= '0;
    end else begin
      lock_q <= lock_sync;
    end
  end

  // Last flag value; zero after reset so no false rise
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      uek_prev_q <= '0;
    end else begin
      uek_prev_q <= uek_flag;
    end
  end

  // Sticky interrupt status
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      irq_status_q <= IRQ_RESET;
    end else begin
      irq_status_q <= irq_status_d;
    end
  end

  // Level output, one cycle behind the status
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // Outputs straight from flip-flops
  assign PRDATA  = prdata_q;
  assign PREADY  = pready_q;
  assign PSLVERR = pslverr_q;
  assign IRQ     = irq_q;

endmodule // lane_status_regs
`default_nettype wire

// [inc/lane_status_pkg.sv]
`default_nettype none
package lane_status_pkg;

  // Geometry
  localparam int unsigned NUM_LANES   = 8;
  localparam int unsigned NUM_LINKS   = 2;
  localparam int unsigned LINK_LANES  = NUM_LANES * NUM_LINKS;
  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned IDX_W       = 14;
  localparam int unsigned IRQ_W       = 16;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_LINK_PAGE  = 14'h0300;
  localparam logic [IDX_W-1:0] IDX_UNEXP_CTRL = 14'h046f;
  localparam logic [IDX_W-1:0] IDX_GROUP_LOCK = 14'h0470;
  localparam logic [IDX_W-1:0] IDX_ERR_THRESH = 14'h0310;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 14'h0320;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 14'h0321;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR  = 14'h0322;
  localparam logic [IDX_W-1:0] IDX_CNT_CLEAR  = 14'h0323;

  // Field positions
  localparam int unsigned PAGE_POS     = 0;
  localparam int unsigned IRQ_UEK_LSB  = 0;
  localparam int unsigned IRQ_LOCK_LSB = 8;

  // Values after reset, and counter limits
  localparam logic [7:0]       THRESH_RESET = 8'h01;
  localparam logic [7:0]       STATUS_RESET = 8'h00;
  localparam logic [7:0]       COUNT_RESET  = 8'h00;
  localparam logic [7:0]       COUNT_MAX    = 8'hff;
  localparam logic [7:0]       COUNT_ONE    = 8'h01;
  localparam logic [IRQ_W-1:0] IRQ_RESET    = 16'h0000;
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

  // Status of one link as the page shows it
  typedef struct packed {
    logic [NUM_LANES-1:0] unexp_flags;
    logic [NUM_LANES-1:0] group_lock;
  } link_status_t;

  // One APB request as presented by the master
  typedef struct packed {
    logic              sel;
    logic              enable;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } apb_req_t;

endpackage
`default_nettype wire

// [design/lane_lock_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module lane_lock_sync
  import lane_status_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [LINK_LANES-1:0] raw_in,
  output logic      [LINK_LANES-1:0] sync_out
);

  logic [LINK_LANES-1:0] meta_q;
  logic [LINK_LANES-1:0] sync_q;

  // Two stages; the first is read by the second only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= raw_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // lane_lock_sync
`default_nettype wire

// [design/lane_error_counter.sv]
`timescale 1ns/100ps
`default_nettype none
module lane_error_counter
  import lane_status_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       err_pulse,
  input  wire logic       clear,
  input  wire logic [7:0] threshold,
  output logic            flag_q
);

  logic [7:0] count_q;
  logic [7:0] count_d;
  logic       flag_d;

  // Saturating count; an error in the clear cycle is kept as the first
  assign count_d = clear ? (err_pulse ? COUNT_ONE : COUNT_RESET) :
                   (err_pulse && (count_q != COUNT_MAX)) ? count_q + COUNT_ONE : count_q;

  // Flag follows the live count against the threshold
  assign flag_d = (count_d >= threshold);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= COUNT_RESET;
      flag_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      flag_q  <= flag_d;
    end
  end

endmodule // lane_error_counter
`default_nettype wire

// [sim/lane_status_regs_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module lane_status_regs_assertions
  import lane_status_pkg::*;
(
  input wire logic              CLK_SYS,
  input wire logic              RST_N,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [DATA_W-1:0] PWDATA,
  input wire logic [DATA_W-1:0] PRDATA,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  input wire logic [15:0]       UNEXP_CTRL_ERR,
  input wire logic [15:0]       GROUP_LOCK_RAW,
  input wire logic              IRQ
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // Setup phase of a transfer and the lock status and link page addresses
  wire logic setup_c = PSEL && !PENABLE;
  localparam logic [15:0] LOCK_A = {IDX_GROUP_LOCK, 2'b00};
  localparam logic [15:0] PAGE_A = {IDX_LINK_PAGE, 2'b00};

  chk_ready_two: assert property (setup_c |=> !PREADY ##1 PREADY)
    else $error("ready not in second access cycle");
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  chk_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  chk_misalign_err: assert property (setup_c && !PWRITE && PADDR[1:0] != 2'b00 |->
                                     ##2 PSLVERR && PRDATA == 32'h0)
    else $error("misaligned read not refused");
  chk_misalign_wr: assert property (setup_c && PWRITE && PADDR[1:0] != 2'b00 |-> ##2 PSLVERR)
    else $error("misaligned write not refused");
  chk_unmapped_err: assert property (setup_c && PADDR == 16'h0000 |-> ##2 PSLVERR)
    else $error("unmapped access not refused");
  chk_lock_width: assert property (setup_c && !PWRITE && PADDR == LOCK_A |->
                                   ##2 !PSLVERR && PRDATA[31:8] == 24'h0)
    else $error("lock read wrong");
  chk_ro_write: assert property (setup_c && PWRITE && PADDR == LOCK_A |-> ##2 !PSLVERR)
    else $error("read-only write refused");
  chk_page_write: assert property (setup_c && PWRITE && PADDR == PAGE_A |-> ##2 !PSLVERR)
    else $error("page write refused");
  chk_rdata_hold: assert property ($changed(PRDATA) |-> PREADY)
    else $error("read data moved between reads");
  chk_reset_clear: assert property ($rose(RST_N) |-> PRDATA == 32'h0 && !IRQ)
    else $error("outputs not clear after reset");

  // Main scenarios reached
  cover property (setup_c && PADDR == LOCK_A);
  cover property (PSLVERR);
  cover property ($rose(IRQ));
endmodule // lane_status_regs_assertions

bind lane_status_regs lane_status_regs_assertions i_chk (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .UNEXP_CTRL_ERR(UNEXP_CTRL_ERR),
  .GROUP_LOCK_RAW(GROUP_LOCK_RAW), .IRQ(IRQ)
);
`default_nettype wire

// [sim/lane_status_regs_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module lane_status_regs_bench;
  import lane_status_pkg::*;
  localparam logic [15:0] A_PAGE = {IDX_LINK_PAGE, 2'b00};
  localparam logic [15:0] A_UEK  = {IDX_UNEXP_CTRL, 2'b00};
  localparam logic [15:0] A_LOCK = {IDX_GROUP_LOCK, 2'b00};
  localparam logic [15:0] A_THR  = {IDX_ERR_THRESH, 2'b00};
  localparam logic [15:0] A_IST  = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [15:0] A_IEN  = {IDX_IRQ_ENABLE, 2'b00};
  localparam logic [15:0] A_ICL  = {IDX_IRQ_CLEAR, 2'b00};
  localparam logic [15:0] A_CNT  = {IDX_CNT_CLEAR, 2'b00};
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [15:0] paddr = 0, uek = 0, lock = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, irq, er;
  int          mismatches = 0, checks_done = 0, cycles = 0;

  always #4 clk = ~clk;

  lane_status_regs i_dut (
    .CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .UNEXP_CTRL_ERR(uek), .GROUP_LOCK_RAW(lock), .IRQ(irq)
  );

  task check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; answer taken at the edge where PREADY is sampled high
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1;
    penable <= 0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel    <= 0;
    penable <= 0;
  endtask

  task pulse(input logic [15:0] m);
    @(posedge clk) uek <= m;
    @(posedge clk) uek <= 16'h0;
  endtask

  task t_reset;
    apb(1, A_LOCK, 32'hff); check(er, 0);
    apb(1, A_UEK, 32'hff);
    apb(0, A_LOCK, 0); check(rd, 0);
    apb(0, A_UEK, 0); check(rd, 0);
    $display("reset values done");
  endtask

  task t_lock;
    lock <= 16'h5aa5;
    repeat (5) @(posedge clk);
    apb(0, A_LOCK, 0); check(rd, 32'ha5);
    apb(1, A_PAGE, 1);
    apb(0, A_LOCK, 0); check(rd, 32'h5a);
    lock <= 16'h00a5;
    repeat (5) @(posedge clk);
    apb(0, A_LOCK, 0); check(rd, 0);
    apb(1, A_PAGE, 0);
    apb(0, A_LOCK, 0); check(rd, 32'ha5);
    $display("lock test done");
  endtask

  task t_flags;
    apb(1, A_THR, 3);
    pulse(16'h0010);
    pulse(16'h0010);
    apb(0, A_UEK, 0); check(rd, 0);
    pulse(16'h0010);
    apb(0, A_UEK, 0); check(rd, 32'h10);
    apb(1, A_PAGE, 1);
    apb(0, A_UEK, 0); check(rd, 0);
    apb(1, A_PAGE, 0);
    apb(1, A_THR, 4);
    apb(0, A_UEK, 0); check(rd, 0);
    apb(1, A_THR, 3);
    repeat (3) pulse(16'hffef);
    apb(0, A_UEK, 0); check(rd, 32'hff);
    apb(1, A_PAGE, 1);
    apb(0, A_UEK, 0); check(rd, 32'hff);
    apb(1, A_CNT, 32'h1);
    apb(0, A_UEK, 0); check(rd, 32'hfe);
    $display("flag test done");
  endtask

  task t_irq;
    repeat (4) @(posedge clk);
    check(irq, 0);
    apb(0, A_IST, 0); check(rd, 32'h0000_5aff);
    apb(1, A_IEN, 32'h1);
    repeat (3) @(posedge clk);
    check(irq, 1);
    apb(1, A_ICL, 32'hff);
    repeat (3) @(posedge clk);
    check(irq, 0);
    apb(0, A_IST, 0); check(rd, 32'h0000_5a00);
    $display("irq test done");
  endtask

  task t_err;
    apb(0, 16'h0000, 0); check(er, 1);
    apb(0, A_LOCK | 16'h1, 0); check({er, rd}, {1'b1, 32'h0});
    apb(1, A_THR | 16'h2, 32'h0); check(er, 1);
    apb(0, A_THR, 0); check(rd, 32'h3);
    $display("error test done");
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      wrap_up;
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    t_reset;
    t_lock;
    t_flags;
    t_irq;
    t_err;
    wrap_up;
  end
endmodule // lane_status_regs_bench
`default_nettype wire
